// *** logic/wake_ctrl_pkg.sv ***
package wake_ctrl_pkg;
	// ****************************************************************
	// line layout
	// ****************************************************************
	localparam int NUM_PIN_LINES = 16;
	localparam int NUM_CMP = 2;
	localparam int NUM_LINES = 21;
	localparam int GPIO_PINS = 32;
	localparam int SEL_W = 5;
	localparam int LEVEL_W = 8;
	localparam int LINE_SUPPLY = 16;
	localparam int LINE_CMP0 = 17;
	localparam int LINE_RTC = 19;
	localparam int LINE_LOW_POWER_TIMER = 20;
	// edge configurable lines: pins, supply detector, comparators
	localparam logic [NUM_LINES-1:0] EDGE_CFG_LINES = 21'h07ffff;

	// ****************************************************************
	// register map (byte offsets)
	// ****************************************************************
	localparam logic [7:0] OFS_RISE_EN = 8'h00;
	localparam logic [7:0] OFS_FALL_EN = 8'h04;
	localparam logic [7:0] OFS_INT_MASK = 8'h08;
	localparam logic [7:0] OFS_WAKE_MASK = 8'h0c;
	localparam logic [7:0] OFS_PENDING = 8'h10;
	localparam logic [7:0] OFS_SEL0 = 8'h14;
	localparam logic [7:0] OFS_SEL1 = 8'h18;
	localparam logic [7:0] OFS_SEL2 = 8'h1c;
	localparam logic [7:0] OFS_SEL3 = 8'h20;
	localparam logic [7:0] OFS_DETECT_CFG = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam int SEL_FIELD_STRIDE = 8;
	localparam int LINES_PER_SEL = 4;
	localparam int DET_SRC_BIT = 8;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
	localparam logic [LEVEL_W-1:0] DET_LEVEL_RESET = 8'h80;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [GPIO_PINS-1:0] gpio;
		logic [NUM_CMP-1:0] cmp;
		logic rtc_wake;
		logic low_power_timer_wake;
	} event_src_s;

	typedef struct packed {
		logic [LEVEL_W-1:0] supply;
		logic [LEVEL_W-1:0] alt_pin;
	} supply_level_s;
endpackage

// *** logic/edge_catcher.sv ***
`timescale 1ns/10ps
module edge_catcher (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// line
	input wire logic sig,
	input wire logic rise_en,
	input wire logic fall_en,
	output logic event_pulse
);
	logic rise_catch;
	logic fall_catch;
	logic sync1_reg;
	logic sync2_reg;
	logic clr_reg;
	// a disabled direction is held clear, so enabling it later cannot replay an old edge
	wire rise_clr = clr_reg | ~presetn | ~rise_en;
	wire fall_clr = clr_reg | ~presetn | ~fall_en;
	wire caught = (rise_catch & rise_en) | (fall_catch & fall_en);

	// ****************************************************************
	// asynchronous capture
	// ****************************************************************
	// the pin edge itself sets the catcher, so pulses narrower than pclk are kept
	always_ff @(posedge sig or posedge rise_clr) begin // [RULE5]
		if (rise_clr) begin
			rise_catch <= 1'b0;
		end else begin
			rise_catch <= 1'b1;
		end
	end

	always_ff @(negedge sig or posedge fall_clr) begin // [RULE5]
		if (fall_clr) begin
			fall_catch <= 1'b0;
		end else begin
			fall_catch <= 1'b1;
		end
	end

	// ****************************************************************
	// synchroniser and handshake back to the catcher
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			clr_reg <= 1'b0;
		end else begin
			sync1_reg <= caught;
			sync2_reg <= sync1_reg;
			clr_reg <= sync2_reg;
		end
	end

	// clr_reg stays high until the cleared catcher drains, giving one pulse per capture
	assign event_pulse = sync2_reg & ~clr_reg; // [RULE2]

	chk_pulse_single: assert property (@(posedge pclk) disable iff (!presetn)
		event_pulse |=> !event_pulse) else $error("event pulse longer than one cycle");
endmodule

// *** logic/supply_detector.sv ***
`timescale 1ns/10ps
module supply_detector
	import wake_ctrl_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// levels and setting
	input wire wake_ctrl_pkg::supply_level_s levels,
	input wire logic use_alt_pin,
	input wire logic [wake_ctrl_pkg::LEVEL_W-1:0] detect_level,
	output logic above_reg
);
	wire logic [LEVEL_W-1:0] watched = use_alt_pin ? levels.alt_pin : levels.supply; // [RULE9]
	wire logic above_next = watched > detect_level; // [RULE9]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			above_reg <= 1'b0;
		end else begin
			above_reg <= above_next;
		end
	end

	chk_det_follow: assert property (@(posedge pclk) disable iff (!presetn)
		##1 above_reg == $past(above_next)) else $error("detector flag lags level"); // [RULE9]
endmodule

// *** logic/event_wakeup_ctrl.sv ***
`timescale 1ns/10ps

// Overview of operation
// RULE1: there are event lines for 16 pins, the supply detector, two comparators, rtc and low power timer wake.
// RULE2: pin, supply detector and comparator lines trigger on rising, falling or both edges.
// RULE3: a select field per pin line routes any gpio pin onto pin lines zero to fifteen.
// RULE4: each line has its own mask bit so software gates each line independently.
// RULE5: edges are captured asynchronously so pulses shorter than one clock are not lost.
// RULE6: each event is held in a pending latch that persists through stop mode for source lookup.
// RULE7: an enabled event raises a wake request to power control to end stop mode.
// RULE8: the supply detector drives line sixteen, interrupting on its configured crossing direction.
// RULE9: the supply detector compares the supply or one alternate pin against a register level.
// RULE10: only pin, supply detector, comparator, rtc and low power timer events can wake the chip.
// RULE11: pending flags stay set until software clears them, and masked lines never interrupt or wake.
module event_wakeup_ctrl
	import wake_ctrl_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire wake_ctrl_pkg::event_src_s sources,
	input wire wake_ctrl_pkg::supply_level_s levels,
	// power control and interrupt
	input wire logic stop_mode,
	output logic wake_req,
	output logic irq,
	output logic supply_above
);
	// ****************************************************************
	// registers
	// ****************************************************************
	logic [NUM_LINES-1:0] rise_en_reg;
	logic [NUM_LINES-1:0] fall_en_reg;
	logic [NUM_LINES-1:0] int_mask_reg;
	logic [NUM_LINES-1:0] wake_mask_reg;
	logic [NUM_LINES-1:0] pending_reg;
	logic [NUM_LINES-1:0] pending_next;
	logic [SEL_W-1:0] sel_reg [NUM_PIN_LINES];
	logic [LEVEL_W-1:0] detect_level_reg;
	logic detect_src_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic irq_reg;
	logic wake_reg;
	wire logic [NUM_LINES-1:0] line_in;
	wire logic [NUM_LINES-1:0] ev;
	logic det_above;

	// ****************************************************************
	// apb decode
	// ****************************************************************
	// one wait state: pready answers the cycle after the access phase starts;
	// masking access with pready keeps a held request from being taken twice
	wire access = psel & penable & ~pready_reg;
	wire wr = access & pwrite;
	wire hit_rise = paddr == OFS_RISE_EN;
	wire hit_fall = paddr == OFS_FALL_EN;
	wire hit_imask = paddr == OFS_INT_MASK;
	wire hit_wmask = paddr == OFS_WAKE_MASK;
	wire hit_pend = paddr == OFS_PENDING;
	wire hit_sel0 = paddr == OFS_SEL0;
	wire hit_sel1 = paddr == OFS_SEL1;
	wire hit_sel2 = paddr == OFS_SEL2;
	wire hit_sel3 = paddr == OFS_SEL3;
	wire hit_det = paddr == OFS_DETECT_CFG;
	wire hit_stat = paddr == OFS_STATUS;
	wire hit_sel = hit_sel0 | hit_sel1 | hit_sel2 | hit_sel3;
	wire mapped = hit_rise | hit_fall | hit_imask | hit_wmask | hit_pend | hit_sel
		| hit_det | hit_stat;
	wire [1:0] sel_grp = hit_sel0 ? 2'h0 : hit_sel1 ? 2'h1 : hit_sel2 ? 2'h2 : 2'h3;
	wire [NUM_LINES-1:0] wdata_lines = pwdata[NUM_LINES-1:0];

	logic [31:0] sel_rdata;
	logic [31:0] rdata;
	always_comb begin
		sel_rdata = RESET_ZERO;
		for (int k = 0; k < LINES_PER_SEL; k++) begin
			sel_rdata[k*SEL_FIELD_STRIDE +: SEL_W] = sel_reg[int'(sel_grp)*LINES_PER_SEL + k];
		end
	end

	always_comb begin
		rdata = RESET_ZERO;
		if (hit_rise) begin
			rdata[NUM_LINES-1:0] = rise_en_reg;
		end else if (hit_fall) begin
			rdata[NUM_LINES-1:0] = fall_en_reg;
		end else if (hit_imask) begin
			rdata[NUM_LINES-1:0] = int_mask_reg;
		end else if (hit_wmask) begin
			rdata[NUM_LINES-1:0] = wake_mask_reg;
		end else if (hit_pend) begin
			rdata[NUM_LINES-1:0] = pending_reg;
		end else if (hit_sel) begin
			rdata = sel_rdata;
		end else if (hit_det) begin
			rdata[LEVEL_W-1:0] = detect_level_reg;
			rdata[DET_SRC_BIT] = detect_src_reg;
		end else if (hit_stat) begin
			rdata[0] = det_above;
			rdata[1] = stop_mode;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= RESET_ZERO;
		end else begin
			pready_reg <= access;
			pslverr_reg <= access & ~mapped;
			prdata_reg <= (access & ~pwrite) ? rdata : RESET_ZERO;
		end
	end

	// ****************************************************************
	// configuration writes
	// ****************************************************************
	// writes force the edge enables on rtc and low power timer lines to rising only; reset clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_en_reg <= RESET_ZERO[NUM_LINES-1:0];
			fall_en_reg <= RESET_ZERO[NUM_LINES-1:0];
			int_mask_reg <= RESET_ZERO[NUM_LINES-1:0];
			wake_mask_reg <= RESET_ZERO[NUM_LINES-1:0];
			detect_level_reg <= DET_LEVEL_RESET;
			detect_src_reg <= 1'b0;
		end else begin
			if (wr & hit_rise) begin
				rise_en_reg <= wdata_lines | ~EDGE_CFG_LINES; // [RULE2]
			end
			if (wr & hit_fall) begin
				fall_en_reg <= wdata_lines & EDGE_CFG_LINES; // [RULE2]
			end
			if (wr & hit_imask) begin
				int_mask_reg <= wdata_lines; // [RULE4]
			end
			if (wr & hit_wmask) begin
				wake_mask_reg <= wdata_lines; // [RULE4]
			end
			if (wr & hit_det) begin
				detect_level_reg <= pwdata[LEVEL_W-1:0]; // [RULE9]
				detect_src_reg <= pwdata[DET_SRC_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_PIN_LINES; i++) begin
				sel_reg[i] <= RESET_ZERO[SEL_W-1:0];
			end
		end else if (wr & hit_sel) begin
			for (int k = 0; k < LINES_PER_SEL; k++) begin
				sel_reg[int'(sel_grp)*LINES_PER_SEL + k] <= pwdata[k*SEL_FIELD_STRIDE +: SEL_W]; // [RULE3]
			end
		end
	end

	// ****************************************************************
	// line sources and edge capture
	// ****************************************************************
	supply_detector u_supply_detector (
		.pclk(pclk),
		.presetn(presetn),
		.levels(levels),
		.use_alt_pin(detect_src_reg),
		.detect_level(detect_level_reg),
		.above_reg(det_above)
	);

	// changing a select field swaps the pin under a live catcher and can look like an edge
	genvar g;
	generate
		for (g = 0; g < NUM_PIN_LINES; g++) begin : g_pin_route
			assign line_in[g] = sources.gpio[sel_reg[g]]; // [RULE3]
		end
	endgenerate

	assign line_in[LINE_SUPPLY] = det_above; // [RULE8]
	assign line_in[LINE_CMP0 +: NUM_CMP] = sources.cmp; // [RULE1]
	assign line_in[LINE_RTC] = sources.rtc_wake; // [RULE1]
	assign line_in[LINE_LOW_POWER_TIMER] = sources.low_power_timer_wake; // [RULE1]

	generate
		for (g = 0; g < NUM_LINES; g++) begin : g_catch
			edge_catcher u_edge_catcher (
				.pclk(pclk),
				.presetn(presetn),
				.sig(line_in[g]),
				.rise_en(rise_en_reg[g]),
				.fall_en(fall_en_reg[g]),
				.event_pulse(ev[g])
			);
		end
	endgenerate

	// ****************************************************************
	// pending latch, interrupt and wake
	// ****************************************************************
	// a new event wins over a write-one clear in the same cycle; masking does not stop latching
	assign pending_next = (pending_reg & ~((wr & hit_pend) ? wdata_lines : '0)) | ev; // [RULE11]

	// only the listed lines exist, so no other source reaches the wake request
	wire wake_any = |(pending_reg & wake_mask_reg); // [RULE10]
	wire irq_any = |(pending_reg & int_mask_reg); // [RULE4]
	// only presetn and a write-one to the pending register clear the latch; stop mode leaves it alone so the waking line can be read

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_reg <= RESET_ZERO[NUM_LINES-1:0];
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			pending_reg <= pending_next; // [RULE6]
			irq_reg <= irq_any; // [RULE8]
			wake_reg <= wake_any; // [RULE7]
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign wake_req = wake_reg;
	assign supply_above = det_above;

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_pend_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(pending_reg != '0) && !(wr && hit_pend) |=> (pending_reg & $past(pending_reg)) == $past(pending_reg))
		else $error("pending flag dropped without clear"); // [RULE11]
	chk_event_latch: assert property (@(posedge pclk) disable iff (!presetn)
		(ev != '0) |=> (pending_reg & $past(ev)) == $past(ev))
		else $error("event not latched"); // [RULE6]
	chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
		(pending_reg & int_mask_reg) == '0 |=> !irq)
		else $error("masked line raised interrupt"); // [RULE4]
	chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
		(pending_reg & int_mask_reg) != '0 |=> irq)
		else $error("unmasked pending did not interrupt"); // [RULE8]
	chk_wake_raise: assert property (@(posedge pclk) disable iff (!presetn)
		(pending_reg & wake_mask_reg) != '0 |=> wake_req)
		else $error("enabled event did not wake"); // [RULE7]
	chk_wake_masked: assert property (@(posedge pclk) disable iff (!presetn)
		(pending_reg & wake_mask_reg) == '0 |=> !wake_req)
		else $error("wake without enabled event"); // [RULE10]
	chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb ready timing wrong");
	chk_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_sel0 |=> sel_reg[0] == $past(pwdata[SEL_W-1:0]))
		else $error("pin select not stored"); // [RULE3]
	chk_fixed_edges: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_rise |=> rise_en_reg[LINE_RTC] && rise_en_reg[LINE_LOW_POWER_TIMER])
		else $error("timer wake lines lost rising enable"); // [RULE2]

	// register stores and bus answers
	chk_rise_store: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_rise |=> rise_en_reg == ($past(wdata_lines) | ~EDGE_CFG_LINES))
		else $error("rising enables not stored"); // [RULE2]
	chk_fall_store: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_fall |=> fall_en_reg == ($past(wdata_lines) & EDGE_CFG_LINES))
		else $error("falling enables not stored"); // [RULE2]
	chk_imask_store: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_imask |=> int_mask_reg == $past(wdata_lines))
		else $error("interrupt mask not stored"); // [RULE4]
	chk_wmask_store: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_wmask |=> wake_mask_reg == $past(wdata_lines))
		else $error("wake mask not stored"); // [RULE4]
	chk_det_store: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_det |=> detect_level_reg == $past(pwdata[LEVEL_W-1:0]))
		else $error("detect level not stored"); // [RULE9]
	chk_pend_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_pend |=> (pending_reg & $past(wdata_lines) & ~$past(ev)) == '0)
		else $error("pending flag not cleared"); // [RULE11]
	chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		access && !mapped |=> pslverr)
		else $error("unmapped access without error");
	chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error response outside ready");
	chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == '0)
		else $error("read data outside ready");
	chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pwrite && hit_stat |=> prdata[1] == $past(stop_mode))
		else $error("status does not show stop mode"); // [RULE6]
endmodule

// *** tb/power_ctrl_model.sv ***
`timescale 1ns/10ps
// ****
// stop mode keeper: leaves stop only on a wake request, promptly or after 3 cycles
// ****
module power_ctrl_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic enter_stop,
	input wire logic slow,
	input wire logic wake_req,
	output logic stop_mode
);
	logic [1:0] cnt_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_mode <= 1'b0;
			cnt_reg <= 2'h0;
		end else if (enter_stop) begin
			stop_mode <= 1'b1;
			cnt_reg <= 2'h0;
		end else if (stop_mode && wake_req) begin
			cnt_reg <= cnt_reg + 2'h1;
			if (!slow || cnt_reg == 2'h2) begin
				stop_mode <= 1'b0;
			end
		end
	end
endmodule

// *** tb/event_wakeup_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module event_wakeup_ctrl_tb_top;
	import wake_ctrl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake_req, supply_above;
	logic enter_stop, slow, stop_mode, e, ab;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	event_src_s src;
	supply_level_s lv;
	logic [20:0] pend, rise, fall, im, wm;
	logic [8:0] det;
	int sel[16];
	int seed, n_errors, compares, g;

	event_wakeup_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sources(src), .levels(lv), .stop_mode(stop_mode),
		.wake_req(wake_req), .irq(irq), .supply_above(supply_above));
	power_ctrl_model partner (.pclk(pclk), .presetn(presetn), .enter_stop(enter_stop),
		.slow(slow), .wake_req(wake_req), .stop_mode(stop_mode));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ****
	// bus and comparison tasks
	// ****
	task summarize;
		begin
			$display("errors %0d compares %0d", n_errors, compares);
			if (n_errors == 0 && compares > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask

	task chk(input string name, input logic [31:0] x, input logic [31:0] s);
		begin
			compares++;
			if (s !== x) begin
				$display("wrong value %s expected %h seen %h", name, x, s);
				n_errors++;
			end
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (pready !== 1'b1 && n < 20);
			if (pready !== 1'b1) begin
				n_errors++;
				summarize();
			end
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		begin
			apb(1'b0, a, 32'h0);
			chk("prdata", x, r);
			chk("pslverr", xe, e);
		end
	endtask

	// model follows every write but the select fields; rtc and timer lines always rise-enabled once written
	task wr(input logic [7:0] a, input logic [31:0] d);
		begin
			apb(1'b1, a, d);
			case (a)
				OFS_RISE_EN: rise = d[20:0] | 21'h180000;
				OFS_FALL_EN: fall = d[20:0] & EDGE_CFG_LINES;
				OFS_INT_MASK: im = d[20:0];
				OFS_WAKE_MASK: wm = d[20:0];
				OFS_PENDING: pend = pend & ~d[20:0];
				OFS_DETECT_CFG: det = d[8:0];
				default: ;
			endcase
			chk("pslverr", 1'b0, e);
		end
	endtask

	// ****
	// event stimulus
	// ****
	task settle;
		begin
			repeat (8) @(posedge pclk);
			rd(OFS_PENDING, 32'(pend), 1'b0);
			chk("irq", |(pend & im), irq);
			chk("wake_req", |(pend & wm), wake_req);
		end
	endtask

	task pin_edge(input int p);
		logic v;
		begin
			v = ~src.gpio[p];
			@(posedge pclk);
			src.gpio[p] <= v;
			for (int j = 0; j < 16; j++) if (sel[j] == p && (v ? rise[j] : fall[j])) pend[j] = 1'b1;
			settle();
		end
	endtask

	task hit(input int ln, input logic v);
		logic o;
		begin
			o = (ln == 17) ? src.cmp[0] : (ln == 18) ? src.cmp[1] :
				(ln == 19) ? src.rtc_wake : src.low_power_timer_wake;
			@(posedge pclk);
			case (ln)
				17: src.cmp[0] <= v;
				18: src.cmp[1] <= v;
				19: src.rtc_wake <= v;
				default: src.low_power_timer_wake <= v;
			endcase
			if (v != o && (v ? rise[ln] : (fall[ln] && ln < 19))) pend[ln] = 1'b1;
			settle();
		end
	endtask

	task lvset(input logic [7:0] s, input logic [7:0] a);
		logic n;
		begin
			n = (det[8] ? a : s) > det[7:0];
			@(posedge pclk);
			lv <= '{supply: s, alt_pin: a};
			if (n != ab && (n ? rise[16] : fall[16])) pend[16] = 1'b1;
			ab = n;
			settle();
			chk("supply_above", ab, supply_above);
			rd(OFS_STATUS, 32'(ab), 1'b0);
		end
	endtask

	initial begin
		seed = 79;
		n_errors = 0;
		compares = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		src = '0;
		lv = '{supply: 8'h10, alt_pin: 8'h00};
		enter_stop = 1'b0;
		slow = 1'b0;
		{pend, rise, fall, im, wm} = '0;
		det = 9'h080;
		ab = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (g = 0; g < 10; g++) rd(8'(4 * g), (g == 9) ? 32'h80 : 32'h0, 1'b0);
		rd(8'h40, 32'h0, 1'b1);
		wr(OFS_RISE_EN, 32'h1fffff);
		wr(OFS_INT_MASK, 32'h1fffff);
		for (g = 0; g < 16; g++) sel[g] = $unsigned($random(seed)) % GPIO_PINS;
		for (g = 0; g < 4; g++) wr(8'(OFS_SEL0 + 4 * g), sel[4 * g] | (sel[4 * g + 1] << 8) |
			(sel[4 * g + 2] << 16) | (sel[4 * g + 3] << 24));
		for (g = 0; g < 16; g++) pin_edge(sel[g]);
		wr(OFS_PENDING, 32'h1fffff);
		settle();
		wr(OFS_FALL_EN, 32'h1fffff);
		wr(OFS_RISE_EN, 32'h0);
		for (g = 0; g < 16; g++) pin_edge(sel[g]);
		hit(17, 1'b1);
		hit(17, 1'b0);
		hit(19, 1'b1);
		hit(20, 1'b1);
		hit(20, 1'b0);
		lvset(8'h81, 8'h00);
		lvset(8'h80, 8'h00);
		wr(OFS_RISE_EN, 32'h10000);
		lvset(8'h81, 8'h00);
		lvset(8'h80, 8'h00);
		wr(OFS_DETECT_CFG, 32'h120);
		lvset(8'h00, 8'h21);
		wr(OFS_PENDING, 32'h1fffff);
		wr(OFS_INT_MASK, 32'h0);
		wr(OFS_WAKE_MASK, 32'h80000);
		wr(OFS_RISE_EN, 32'h1fffff);
		hit(19, 1'b0);
		@(posedge pclk);
		enter_stop <= 1'b1;
		slow <= 1'b1;
		@(posedge pclk);
		enter_stop <= 1'b0;
		hit(18, 1'b1);
		chk("stop_mode", 1'b1, stop_mode);
		rd(OFS_STATUS, 32'h3, 1'b0);
		hit(19, 1'b1);
		chk("stop_mode", 1'b0, stop_mode);
		wr(OFS_PENDING, 32'h1fffff);
		wr(OFS_INT_MASK, 32'h1fffff);
		wr(OFS_RISE_EN, 32'h1fffff);
		@(negedge pclk);
		src.gpio[sel[0]] = 1'b1;
		#2 src.gpio[sel[0]] = 1'b0;
		for (g = 0; g < 16; g++) if (sel[g] == sel[0]) pend[g] = 1'b1;
		settle();
		summarize();
	end
endmodule
